// ### rtl/cms_pkg.sv
// Purpose: shared constants and types of the message store block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: message is four 32-bit words, identifier word first
package cms_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS = 8'h00; // interrupt_flag_register
  localparam logic [7:0] OFS_ACK = 8'h04;   // interrupt_acknowledge
  localparam logic [7:0] OFS_RXQ = 8'h08;   // receive queue read window
  localparam logic [7:0] OFS_TXQ = 8'h0c;   // transmit queue write window
  localparam logic [7:0] OFS_HPB = 8'h10;   // priority_tx_buffer window
  localparam logic [7:0] OFS_STAT = 8'h14;  // fill levels and busy

  // ------------------------------------------------------------
  // flag bit positions, shared by flags and acknowledge bits
  // ------------------------------------------------------------
  localparam int FLG_ARB = 0;    // arb_lost_flag
  localparam int FLG_TX_DONE_FLAG = 1;   // tx_done_flag
  localparam int FLG_TX_QUEUE_FULL_FLAG = 2;  // tx_queue_full_flag
  localparam int FLG_HPBFL = 3;  // prio_buf_full_flag
  localparam int FLG_RX_DONE_FLAG = 4;   // rx_done_flag
  localparam int FLG_RXUF = 5;   // rx_underflow_flag
  localparam int FLG_RXOF = 6;   // rx_overflow_flag
  localparam int FLG_RXNE = 7;   // rx_not_empty_flag
  localparam int FLG_ERR = 8;    // error flag
  localparam int FLG_BOFF = 9;   // bus_off_flag
  localparam int FLG_SLP = 10;   // sleep_flag
  localparam int FLG_WAKE = 11;  // wake_flag
  localparam int NUM_FLAGS = 12;
  localparam int RSV_LSB = 12;   // reserved read/write bits 31:12
  localparam int RSV_W = 20;

  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 12'h000;
  localparam logic [RSV_W-1:0] RSV_RST = 20'h00000;

  // ------------------------------------------------------------
  // queue depths, chosen at build time, at most 64 messages
  // ------------------------------------------------------------
  localparam int MAX_DEPTH = 64;
  localparam int RXQ_DEPTH = 64;
  localparam int TXQ_DEPTH = 64;
  localparam int CNT_W = 7;      // holds 0..64
  localparam int WORDS = 4;      // words per message

  // ------------------------------------------------------------
  // message words
  // ------------------------------------------------------------
  localparam int ID_BASE_MSB = 31;  // base identifier 31:21
  localparam int ID_BASE_LSB = 21;
  localparam int ID_SRR = 20;       // substitute / remote request
  localparam int ID_EXT = 19;       // extension flag
  localparam int ID_XID_MSB = 18;   // extended identifier 18:1
  localparam int ID_XID_LSB = 1;
  localparam int ID_RTR = 0;        // remote request
  localparam int LEN_MSB = 31;      // data length code 31:28
  localparam int LEN_LSB = 28;

  // one message, identifier word most significant
  typedef struct packed {
    logic [31:0] id;   // message_identifier_word
    logic [31:0] len;  // message_length_word
    logic [31:0] d1;   // message_payload_word_one, byte zero high
    logic [31:0] d2;   // message_payload_word_two, byte seven low
  } cms_msg_t;

  // transmit arbiter states
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} cms_tx_state_t;

endpackage : cms_pkg

// ### rtl/cms_fifo.sv
// Purpose: message queue of build-time depth
// Assumes: caller never pushes when full nor pops when empty
// Notes: head message is visible without popping
`timescale 1ns/1ps
module cms_fifo import cms_pkg::*; #(
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic push,
  input wire cms_msg_t din,
  input wire logic pop,
  output cms_msg_t dout,
  output logic full,
  output logic empty,
  output logic [CNT_W-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  cms_msg_t mem [DEPTH];          // message store, kept through bus-off
  logic [AW-1:0] wr_ptr_reg;      // next slot to fill
  logic [AW-1:0] rd_ptr_reg;      // head slot
  logic [CNT_W-1:0] count_reg;    // messages held

  assign dout = mem[rd_ptr_reg];
  assign full = (count_reg == CNT_W'(DEPTH));
  assign empty = (count_reg == '0);
  assign count = count_reg;

  // storage has no reset: contents survive mode changes
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= din;
    end
  end

  // pointers wrap at the configured depth
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule : cms_fifo

// ### rtl/cms_asm.sv
// Purpose: gathers four written words into one message
// Assumes: words arrive identifier, length, payload one, payload two
// Notes: writes are dropped while blocked
`timescale 1ns/1ps
module cms_asm import cms_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic blocked,
  output cms_msg_t msg,
  output logic msg_valid
);
  logic [1:0] idx_reg;          // word position within message
  logic [95:0] part_reg;        // first three words
  wire take = wr_en & ~blocked;
  wire last = (idx_reg == 2'(WORDS - 1));

  assign msg = cms_msg_t'({part_reg, wdata});
  assign msg_valid = take & last;

  // shift words in; fourth word completes the message
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_reg <= '0;
      part_reg <= '0;
    end else if (ce && take) begin
      idx_reg <= idx_reg + 2'd1;
      part_reg <= {part_reg[63:0], wdata};
    end
  end
endmodule : cms_asm

// ### rtl/cms_core.sv
// Purpose: flag clearing, message queues and transmit arbitration
// Assumes: link engine and filters run on clk; apb zero wait
// Notes: queue contents survive bus-off and configuration mode
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

// Functional notes
// - ack bits 11,10 clear wake, sleep
// - ack bits 9,8 clear bus-off, error
// - ack bits 7..4 clear receive flags
// - ack bits 3..0 clear transmit flags
// - upper bits read/write, ack bits write-only
// - receive queue depth build-time, max 64
// - transmit queue depth build-time, max 64
// - frame stored when an enabled filter passes
// - no filter selected stores every frame
// - one-message priority transmit buffer
// - priority buffer wins over transmit queue
// - lost or errored frame is retried
// - no other frame until current succeeds
// - stores kept in bus-off, configuration
// - identifier word field layout
// - length code in bits 31:28
// - payload word one holds bytes 0-3
// - payload word two holds bytes 4-7
// - message read as four words
// - writes to receive queue ignored
module cms_core import cms_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive side, from filters and link engine
  input wire logic rx_valid,
  input wire cms_msg_t rx_msg,
  input wire logic filt_any_en,
  input wire logic filt_hit,
  // transmit side, to link engine
  output logic tx_valid,
  output cms_msg_t tx_msg,
  input wire logic tx_done,
  input wire logic tx_arb_lost,
  input wire logic tx_error,
  // controller state events
  input wire logic cfg_mode,
  input wire logic bus_off_evt,
  input wire logic wake_evt,
  input wire logic sleep_evt
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire setup = psel & ~penable;           // address phase
  wire access = psel & penable;           // answer phase, no wait
  wire sel_flags = (paddr == OFS_FLAGS);
  wire sel_ack = (paddr == OFS_ACK);
  wire sel_rxq = (paddr == OFS_RXQ);
  wire sel_txq = (paddr == OFS_TXQ);
  wire sel_hpb = (paddr == OFS_HPB);
  wire sel_stat = (paddr == OFS_STAT);
  wire sel_ok = sel_flags | sel_ack | sel_rxq | sel_txq | sel_hpb
              | sel_stat;
  wire wr_ack = access & pwrite & sel_ack;
  wire rd_rxq = access & ~pwrite & sel_rxq;
  wire wr_txq = access & pwrite & sel_txq;
  wire wr_hpb = access & pwrite & sel_hpb;

  assign pready = 1'b1;                   // every access ends at once
  assign pslverr = access & ~sel_ok;      // unmapped address

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flags_reg;        // interrupt_flag_register
  logic [NUM_FLAGS-1:0] flags_next;
  logic [NUM_FLAGS-1:0] flag_set;         // hardware events
  logic [NUM_FLAGS-1:0] flag_clr;         // acknowledge ones
  logic [RSV_W-1:0] rsv_reg;              // reserved ack bits 31:12
  logic [31:0] prdata_reg;                // read data, caught at setup
  logic [31:0] prdata_next;
  logic [1:0] rd_idx_reg;                 // word of head being read
  cms_tx_state_t state_reg;               // transmit arbiter
  cms_tx_state_t state_next;
  logic src_hpb_reg;                      // frame came from buffer
  cms_msg_t cur_reg;                      // frame on the wire
  cms_msg_t hpb_msg_reg;                  // priority_tx_buffer
  logic hpb_full_reg;

  // ------------------------------------------------------------
  // queues and word gathering
  // ------------------------------------------------------------
  cms_msg_t rxq_head;
  cms_msg_t txq_head;
  cms_msg_t txq_in;
  cms_msg_t hpb_in;
  logic rxq_full, rxq_empty, txq_full, txq_empty;
  logic txq_load, hpb_load;
  logic [CNT_W-1:0] rxq_cnt, txq_cnt;

  // frame kept if any enabled filter passes, or none enabled
  wire rx_store_try = rx_valid & (~filt_any_en | filt_hit);
  wire rx_push = rx_store_try & ~rxq_full;
  wire rx_drop = rx_store_try & rxq_full;
  wire rx_last = (rd_idx_reg == 2'(WORDS - 1));
  wire rx_pop = rd_rxq & ~rxq_empty & rx_last;
  wire rx_under = rd_rxq & rxq_empty;
  wire pick = (state_reg == ST_IDLE) & ~cfg_mode;
  wire pick_hpb = pick & hpb_full_reg;
  wire pick_txq = pick & ~hpb_full_reg & ~txq_empty;
  wire release_tx = (state_reg == ST_BUSY) & tx_done;
  wire txq_pop = release_tx & ~src_hpb_reg;
  wire hpb_free = release_tx & src_hpb_reg;

  cms_fifo #(.DEPTH(RXQ_DEPTH)) u_rxq (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .push(rx_push),
    .din(rx_msg),
    .pop(rx_pop),
    .dout(rxq_head),
    .full(rxq_full),
    .empty(rxq_empty),
    .count(rxq_cnt)
  );

  cms_fifo #(.DEPTH(TXQ_DEPTH)) u_txq (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .push(txq_load),
    .din(txq_in),
    .pop(txq_pop),
    .dout(txq_head),
    .full(txq_full),
    .empty(txq_empty),
    .count(txq_cnt)
  );

  // full queue drops further words; gathering resumes after a pop
  cms_asm u_txq_asm (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_en(wr_txq),
    .wdata(pwdata),
    .blocked(txq_full),
    .msg(txq_in),
    .msg_valid(txq_load)
  );

  // full buffer refuses writes until its frame is sent
  cms_asm u_hpb_asm (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_en(wr_hpb),
    .wdata(pwdata),
    .blocked(hpb_full_reg),
    .msg(hpb_in),
    .msg_valid(hpb_load)
  );

  // ------------------------------------------------------------
  // flags: set wins over a clear in the same cycle
  // ------------------------------------------------------------
  assign flag_set[FLG_ARB] = (state_reg == ST_BUSY) & tx_arb_lost;
  assign flag_set[FLG_TX_DONE_FLAG] = release_tx;
  assign flag_set[FLG_TX_QUEUE_FULL_FLAG] = txq_load
                             & (txq_cnt == CNT_W'(TXQ_DEPTH - 1));
  assign flag_set[FLG_HPBFL] = hpb_load;
  assign flag_set[FLG_RX_DONE_FLAG] = rx_push;
  assign flag_set[FLG_RXUF] = rx_under;
  assign flag_set[FLG_RXOF] = rx_drop;
  assign flag_set[FLG_RXNE] = rx_push;
  assign flag_set[FLG_ERR] = (state_reg == ST_BUSY) & tx_error;
  assign flag_set[FLG_BOFF] = bus_off_evt;
  assign flag_set[FLG_SLP] = sleep_evt;
  assign flag_set[FLG_WAKE] = wake_evt;

  // a one clears, a zero leaves the flag alone
  assign flag_clr = wr_ack ? pwdata[NUM_FLAGS-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      assign flags_next[gi] = flag_set[gi]
                            | (flags_reg[gi] & ~flag_clr[gi]);
    end
  endgenerate

  // flag and reserved registers
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= FLAGS_RST;
      rsv_reg <= RSV_RST;
    end else if (ce) begin
      flags_reg <= flags_next;
      if (wr_ack) rsv_reg <= pwdata[31:RSV_LSB];
    end
  end

  // ------------------------------------------------------------
  // read data: ack bits read zero, transmit windows read zero
  // ------------------------------------------------------------
  wire [31:0] rx_word = (rd_idx_reg == 2'd0) ? rxq_head.id
                      : (rd_idx_reg == 2'd1) ? rxq_head.len
                      : (rd_idx_reg == 2'd2) ? rxq_head.d1
                      : rxq_head.d2;
  wire [31:0] stat_word = {16'h0000, 1'b0, txq_cnt, 1'b0, rxq_cnt}
                        | {hpb_full_reg, (state_reg == ST_BUSY), 30'h0};

  assign prdata_next = sel_flags ? {20'h00000, flags_reg}
                     : sel_ack ? {rsv_reg, 12'h000}
                     : (sel_rxq & ~rxq_empty) ? rx_word
                     : sel_stat ? stat_word
                     : 32'h0000_0000;
  assign prdata = prdata_reg;

  // read data caught one edge before the answer phase
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_reg <= '0;
    end else if (ce && setup && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  // word pointer for receive reads; writes never touch it
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_idx_reg <= '0;
    end else if (ce && rd_rxq && !rxq_empty) begin
      rd_idx_reg <= rd_idx_reg + 2'd1;
    end
  end

  // ------------------------------------------------------------
  // priority buffer
  // ------------------------------------------------------------
  // single slot; configuration mode never flushes it
  always_ff @(posedge clk) begin
    if (reset) begin
      hpb_full_reg <= 1'b0;
      hpb_msg_reg <= '0;
    end else if (ce) begin
      if (hpb_load) begin
        hpb_full_reg <= 1'b1;
        hpb_msg_reg <= hpb_in;
      end else if (hpb_free) begin
        hpb_full_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit arbiter
  // ------------------------------------------------------------
  // busy holds through losses and errors, so the same frame retries
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pick_hpb || pick_txq) state_next = ST_BUSY;
      end
      ST_BUSY: begin
        if (tx_done) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // frame latched at pick, kept until success
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      src_hpb_reg <= 1'b0;
      cur_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      if (pick_hpb || pick_txq) begin
        src_hpb_reg <= pick_hpb;
        cur_reg <= pick_hpb ? hpb_msg_reg : txq_head;
      end
    end
  end

  assign tx_valid = (state_reg == ST_BUSY);
  assign tx_msg = cur_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ack_clear_a: assert property (ce && wr_ack && pwdata[FLG_WAKE]
    && !flag_set[FLG_WAKE] |=> !flags_reg[FLG_WAKE])
    else $error("wake flag not cleared");
  ack_bus_off_a: assert property (ce && wr_ack && pwdata[FLG_BOFF]
    && !bus_off_evt |=> !flags_reg[FLG_BOFF])
    else $error("bus-off flag not cleared");
  set_wins_a: assert property (ce && rx_push |=> flags_reg[FLG_RX_DONE_FLAG]
    && flags_reg[FLG_RXNE])
    else $error("receive event lost");
  ack_zero_a: assert property (ce && wr_ack && !pwdata[FLG_TX_DONE_FLAG]
    && flags_reg[FLG_TX_DONE_FLAG] |=> flags_reg[FLG_TX_DONE_FLAG])
    else $error("flag cleared by zero");
  ack_read_a: assert property (access && !pwrite && sel_ack
    |-> prdata[NUM_FLAGS-1:0] == 12'h000)
    else $error("ack bits not write-only");
  rx_filter_a: assert property (ce && rx_valid && filt_any_en
    && !filt_hit |=> rxq_cnt == $past(rxq_cnt) - CNT_W'($past(rx_pop)))
    else $error("filtered frame stored");
  hpb_first_a: assert property (ce && pick && hpb_full_reg
    && !txq_empty |=> src_hpb_reg && tx_msg == $past(hpb_msg_reg))
    else $error("queue beat priority buffer");
  retry_hold_a: assert property (ce && tx_valid && !tx_done
    |=> tx_valid && $stable(tx_msg))
    else $error("frame dropped before success");
  rx_write_a: assert property (ce && access && pwrite && sel_rxq
    && !rx_push |=> $stable(rxq_cnt) && $stable(rd_idx_reg))
    else $error("receive queue written");

  cover_retry_c: cover property (tx_valid && tx_arb_lost ##[1:16] tx_done);
  cover_hpb_c: cover property (pick_hpb && !txq_empty);
  cover_rxmsg_c: cover property (rx_pop ##[1:4] rx_under);

endmodule : cms_core

// ### bench/cms_link_model.sv
// Purpose: far-side link engine model for the message store core
// Assumes: pulses only while tx_valid is high, one attempt at a time
// Notes: n_fail failed attempts precede every successful send
`timescale 1ns/1ps
module cms_link_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic [1:0] n_fail,
  output logic tx_done,
  output logic tx_arb_lost,
  output logic tx_error
);
  int wait_c; // cycles into the current attempt
  int fails; // failed attempts of this frame

  // --------------------------------------------------------------
  // attempt engine
  // --------------------------------------------------------------
  // later attempts take longer, so prompt and slow answers both occur
  always @(posedge clk) begin
    tx_done <= 1'b0;
    tx_arb_lost <= 1'b0;
    tx_error <= 1'b0;
    if (reset || tx_valid !== 1'b1) begin
      wait_c <= 0;
      fails <= 0;
    end else if (wait_c < 3 + 2 * fails) begin
      wait_c <= wait_c + 1;
    end else begin
      wait_c <= 0;
      if (fails < n_fail) begin
        fails <= fails + 1;
        if (fails % 2 == 0) tx_arb_lost <= 1'b1;
        else tx_error <= 1'b1;
      end else begin
        tx_done <= 1'b1;
      end
    end
  end
endmodule : cms_link_model

// ### bench/can_msg_store_irq_clear_test.sv
// Purpose: self-checking bench of the message store core
// Assumes: zero-wait apb slave, link engine modelled beside the core
// Notes: queues hold expected frames; flags tracked as a vector
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module can_msg_store_irq_clear_test import cms_pkg::*; ();
  logic clk, reset, psel, penable, pwrite, slv, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic rx_valid, filt_any_en, filt_hit, tx_valid, a, prev_v;
  logic tx_done, tx_arb_lost, tx_error;
  logic cfg_mode, bus_off_evt, wake_evt, sleep_evt;
  logic ce; // clock enable, dropped once to check the freeze
  cms_msg_t rx_msg, tx_msg, prev_m, m, hpb0, hpb1;
  cms_msg_t rxq[$], txq[$], es[$], got[$]; // reference queues
  logic [11:0] fl; // expected flag vector
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 17224;

  always #2 clk = ~clk;

  cms_core u_cms_core (.clk(clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_msg(rx_msg),
    .filt_any_en(filt_any_en), .filt_hit(filt_hit),
    .tx_valid(tx_valid), .tx_msg(tx_msg), .tx_done(tx_done),
    .tx_arb_lost(tx_arb_lost), .tx_error(tx_error),
    .cfg_mode(cfg_mode), .bus_off_evt(bus_off_evt),
    .wake_evt(wake_evt), .sleep_evt(sleep_evt));

  cms_link_model u_cms_link_model (.clk(clk), .reset(reset),
    .tx_valid(tx_valid), .n_fail(2'd3), .tx_done(tx_done),
    .tx_arb_lost(tx_arb_lost), .tx_error(tx_error));

  // --------------------------------------------------------------
  // link watch: frame held steady, sent frames logged
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && prev_v === 1'b1)
      `CHK("tx_msg", prev_m, tx_msg)
    if (tx_valid === 1'b1 && tx_done === 1'b1) got.push_back(tx_msg);
    prev_v <= tx_valid;
    prev_m <= tx_msg;
  end

  function automatic cms_msg_t rmsg();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction : rmsg

  // one apb transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d, output logic [31:0] rv);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] rv;
    apb(1'b1, ad, d, rv);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
      input string n);
    logic [31:0] rv;
    apb(1'b0, ad, 32'h0, rv);
    `CHK(n, e, rv)
  endtask : rd

  // whole message, identifier word first
  task automatic wmsg(input logic [7:0] ad, input cms_msg_t fm);
    for (int w = 0; w < WORDS; w++)
      wr(ad, fm[127 - 32 * w -: 32]);
  endtask : wmsg

  // one received frame; model keeps what passes and fits
  task automatic rx_frame(input cms_msg_t fm, input logic an,
      input logic hit);
    rx_valid <= 1'b1;
    rx_msg <= fm;
    filt_any_en <= an;
    filt_hit <= hit;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
    if ((!an || hit) && rxq.size() < RXQ_DEPTH) rxq.push_back(fm);
  endtask : rx_frame

  task automatic wait_got(input int n);
    while (got.size() < n)
      @(posedge clk);
  endtask : wait_got

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // watchdog, several times the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_valid, rx_msg, filt_any_en, filt_hit} = '0;
    {cfg_mode, bus_off_evt, wake_evt, sleep_evt} = 4'h0;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(OFS_FLAGS, 32'h0, "flags rst");
    rd(OFS_ACK, 32'h0, "ack rst");
    r = $random(seed);
    wr(OFS_ACK, r);
    rd(OFS_ACK, {r[31:12], 12'h000}, "ack rsv");
    apb(1'b0, 8'h3c, 32'h0, r);
    `CHK("slverr", 1'b1, slv)
    // filtered-out frame, then fill one past the depth
    rx_frame(rmsg(), 1'b1, 1'b0);
    for (int i = 0; i <= RXQ_DEPTH; i++) begin
      a = 1'($random(seed));
      rx_frame(rmsg(), a, a | 1'($random(seed)));
    end
    wr(OFS_RXQ, $random(seed));
    // configuration mode: stores fill but nothing is sent
    cfg_mode <= 1'b1;
    for (int i = 0; i <= TXQ_DEPTH; i++) begin
      m = rmsg();
      if (i < TXQ_DEPTH) txq.push_back(m);
      wmsg(OFS_TXQ, m);
    end
    hpb0 = rmsg();
    wmsg(OFS_HPB, hpb0);
    wmsg(OFS_HPB, rmsg());
    {bus_off_evt, wake_evt, sleep_evt} <= 3'b111;
    @(posedge clk);
    {bus_off_evt, wake_evt, sleep_evt} <= 3'b000;
    @(posedge clk);
    apb(1'b0, OFS_STAT, 32'h0, r);
    `CHK("rx count", 7'd64, r[6:0])
    `CHK("tx count", 7'd64, r[14:8])
    `CHK("hpb full", 1'b1, r[31])
    rd(OFS_TXQ, 32'h0, "txq read");
    while (rxq.size() > 0) begin
      m = rxq.pop_front();
      for (int w = 0; w < WORDS; w++)
        rd(OFS_RXQ, m[127 - 32 * w -: 32], "rx word");
    end
    // empty read: value not used, only the underflow flag
    apb(1'b0, OFS_RXQ, 32'h0, r);
    // leave configuration; second priority frame joins mid-flight
    cfg_mode <= 1'b0;
    wait_got(1);
    hpb1 = rmsg();
    wmsg(OFS_HPB, hpb1);
    wait_got(TXQ_DEPTH + 2);
    es = {hpb0, txq[0], hpb1, txq[1:$]};
    `CHK("sent n", TXQ_DEPTH + 2, got.size())
    foreach (es[i]) `CHK("sent msg", es[i], got[i])
    rd(OFS_FLAGS, 32'h00000fff, "flags all");
    fl = 12'hfff;
    // frozen core must ignore a clear-all write
    ce <= 1'b0;
    wr(OFS_ACK, 32'h0000_0fff);
    ce <= 1'b1;
    wr(OFS_ACK, 32'h0);
    rd(OFS_FLAGS, {20'h0, fl}, "flags kept");
    for (int i = 0; i < NUM_FLAGS; i++) begin
      fl[i] = 1'b0;
      wr(OFS_ACK, 32'h1 << i);
      rd(OFS_FLAGS, {20'h0, fl}, "flag clr");
    end
    finish_test;
  end
endmodule : can_msg_store_irq_clear_test
